// ### design/ts_byte_fifo.v
// Purpose: small byte FIFO between packet rewrite and output
// Assumes: one clock, asynchronous active-low reset
// Notes: full flag is registered so upstream ready is a flop
`timescale 1ns/1ps
module ts_byte_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_in,
    input wire arst_n_in,
    input wire wr_valid_in,
    output wire wr_ready_out,
    input wire [WIDTH-1:0] wr_data_in,
    output wire rd_valid_out,
    input wire rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    reg full_q;
    wire do_wr = wr_valid_in && !full_q;
    wire do_rd = rd_ready_in && (cnt_q != {(AW+1){1'b0}});
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

    assign wr_ready_out = !full_q;
    assign rd_valid_out = cnt_q != {(AW+1){1'b0}};
    assign rd_data_out = mem[rp_q];

    always @(posedge clk_in) begin
        if (do_wr) begin
            mem[wp_q] <= wr_data_in;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            full_q <= 1'b0;
        end else begin
            if (do_wr) begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            full_q <= cnt_d == DEPTH[AW:0];
        end
    end
endmodule // ts_byte_fifo

// ### design/ts_channel_mux_config.v
// Purpose: slot map, PID map, channel PID insert, policing, protection
// Assumes: config inputs are static or from core logic; fail pins async
// Notes: the last two bytes of a packet leave when the next one arrives
`timescale 1ns/1ps
`include "ts_mux_consts.vh"
module ts_channel_mux_config #(
    parameter [32:0] STABLE_CYCLES = 33'h1_bf08_eb00,
    parameter FIFO_DEPTH = 4
) (
    input wire clk_in,
    input wire arst_n_in,
    // Function map
    input wire [15:0] slot_type_in,
    input wire [7:0] slot_tx_in,
    output reg [7:0] port_tx_out,
    output reg [7:0] port_drive_n_out,
    output reg [7:0] port_rx_en_out,
    output reg [7:0] slot_en_out,
    // Demux PID map
    input wire map_wr_in,
    input wire [7:0] map_wr_idx_in,
    input wire [12:0] map_wr_pid_in,
    input wire [7:0] map_rd_idx_in,
    output reg [15:0] map_rd_pid_out,
    input wire [3:0] elem_sel_in,
    output reg [15:0] def_pid_out,
    // IP interface entry
    input wire [11:0] vlan_id_in,
    input wire [7:0] ttl_in,
    output reg vlan_tagged_out,
    output reg [11:0] vlan_tag_out,
    output reg [7:0] ttl_out,
    // Data Ethernet protection
    input wire [1:0] prot_mode_in,
    input wire pri_fail_in,
    input wire sec_fail_in,
    output reg sec_sel_out,
    // Virtual channel settings
    input wire chan_is_pid_in,
    input wire [12:0] chan_match_pid_in,
    input wire [12:0] chan_pid_in,
    input wire [15:0] prog_num_in,
    input wire prog_match_in,
    input wire pid_conflict_in,
    input wire resource_over_in,
    input wire [7:0] stream_type_in,
    input wire [7:0] police_rate_in,
    input wire low_prio_in,
    output reg pat_entry_out,
    output reg pmt_elem_out,
    output reg [7:0] elem_stream_type_out,
    output reg low_prio_out,
    output reg cfg_err_out,
    // Packet stream
    input wire in_valid_in,
    input wire in_sop_in,
    input wire [7:0] in_data_in,
    output reg in_ready_out,
    output reg out_valid_out,
    output reg [7:0] out_data_out,
    input wire out_ready_in
);
    // Function map
    wire [7:0] drive_d;
    wire [7:0] rx_d;
    wire [7:0] en_d;
    wire [7:0] tx_d;
    wire [7:0] copy_bad;
    genvar gi;
    generate
        for (gi = 0; gi < `SLOTS; gi = gi + 1) begin : g_slot
            wire [1:0] ty = slot_type_in[2*gi+1:2*gi];
            // Even slots sit at odd indices; slot 1 is index 0
            wire copy_ok;
            wire prev_tx;
            if (gi % 2 == 1) begin : g_even
                assign copy_ok = ty == `TYPE_COPY &&
                    slot_type_in[2*gi-1:2*gi-2] == `TYPE_MUX;
                assign prev_tx = slot_tx_in[gi-1];
            end else begin : g_odd
                // Odd slots do not mirror their left neighbour
                assign copy_ok = 1'b0;
                assign prev_tx = 1'b0;
            end
            assign drive_d[gi] = ty == `TYPE_MUX || copy_ok;
            assign rx_d[gi] = ty == `TYPE_DMX;
            // An illegal copy leaves slot and port dark
            assign en_d[gi] = ty != `TYPE_OFF &&
                (ty != `TYPE_COPY || copy_ok);
            assign copy_bad[gi] = ty == `TYPE_COPY && !copy_ok;
            assign tx_d[gi] = copy_ok ? prev_tx :
                (ty == `TYPE_MUX) & slot_tx_in[gi];
        end
    endgenerate

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_tx_out <= 8'h00;
            port_drive_n_out <= 8'hff;
            port_rx_en_out <= 8'h00;
            slot_en_out <= 8'h00;
        end else begin
            port_tx_out <= tx_d;
            port_drive_n_out <= ~drive_d;
            port_rx_en_out <= rx_d;
            slot_en_out <= en_d;
        end
    end

    // Demux PID map; valid bits reset, contents need none
    reg [12:0] map_mem [0:`MAP_ENTRIES-1];
    reg [`MAP_ENTRIES-1:0] map_vld_q;
    always @(posedge clk_in) begin
        // Writes past the last entry are dropped
        if (map_wr_in && map_wr_idx_in < `MAP_ENTRIES) begin
            map_mem[map_wr_idx_in] <= map_wr_pid_in;
        end
    end
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            map_vld_q <= {`MAP_ENTRIES{1'b0}};
            map_rd_pid_out <= `PID_NONE;
            def_pid_out <= `PID_NONE;
        end else begin
            if (map_wr_in && map_wr_idx_in < `MAP_ENTRIES) begin
                map_vld_q[map_wr_idx_in] <= 1'b1;
            end
            if (map_rd_idx_in < `MAP_ENTRIES &&
                    map_vld_q[map_rd_idx_in]) begin
                map_rd_pid_out <= {3'h0, map_mem[map_rd_idx_in]};
            end else begin
                map_rd_pid_out <= `PID_NONE;
            end
            // Slot 13 between data and ECM has no default
            if (elem_sel_in <= `ELEM_DATA2 || elem_sel_in == `ELEM_ECM) begin
                def_pid_out <= {3'h0, `PID_BASE + {9'h000, elem_sel_in}};
            end else begin
                def_pid_out <= `PID_NONE;
            end
        end
    end

    // IP entry
    // 4095 is reserved and stays untagged
    wire vlan_bad = vlan_id_in > `VLAN_MAX;
    wire ttl_bad = ttl_in < `TTL_MIN;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vlan_tagged_out <= 1'b0;
            vlan_tag_out <= 12'h000;
            ttl_out <= `TTL_MIN;
        end else begin
            vlan_tagged_out <= vlan_id_in != 12'h000 && !vlan_bad;
            vlan_tag_out <= vlan_bad ? 12'h000 : vlan_id_in;
            // A zero TTL would never leave the box; hold the floor
            ttl_out <= ttl_bad ? `TTL_MIN : ttl_in;
        end
    end

    // Fail pins: three flops, change accepted when the last two agree
    reg [2:0] pf_q;
    reg [2:0] sf_q;
    reg pri_fail_q;
    reg sec_fail_q;
    reg [32:0] stable_q;
    reg state_q;
    localparam ST_PRI = 1'b0;
    localparam ST_SEC = 1'b1;
    // Timer restarts on every primary failure
    wire stable_ok = stable_q >= STABLE_CYCLES;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pf_q <= 3'h0;
            sf_q <= 3'h0;
            pri_fail_q <= 1'b0;
            sec_fail_q <= 1'b0;
            stable_q <= 33'h0_0000_0000;
            state_q <= ST_PRI;
            sec_sel_out <= 1'b0;
        end else begin
            pf_q <= {pf_q[1:0], pri_fail_in};
            sf_q <= {sf_q[1:0], sec_fail_in};
            if (pf_q[1] == pf_q[2]) begin
                pri_fail_q <= pf_q[2];
            end
            if (sf_q[1] == sf_q[2]) begin
                sec_fail_q <= sf_q[2];
            end
            if (pri_fail_q) begin
                stable_q <= 33'h0_0000_0000;
            end else if (!stable_ok) begin
                stable_q <= stable_q + 33'h0_0000_0001;
            end
            case (state_q)
                ST_PRI: begin
                    if (prot_mode_in == `PROT_AUTO && pri_fail_q) begin
                        state_q <= ST_SEC;
                    end
                end
                ST_SEC: begin
                    if (prot_mode_in != `PROT_AUTO) begin
                        state_q <= ST_PRI;
                    end else if (sec_fail_q && stable_ok) begin
                        state_q <= ST_PRI;
                    end
                end
                default: state_q <= ST_PRI;
            endcase
            case (prot_mode_in)
                `PROT_PRI: sec_sel_out <= 1'b0;
                `PROT_SEC: sec_sel_out <= 1'b1;
                `PROT_AUTO: sec_sel_out <= state_q == ST_SEC;
                default: sec_sel_out <= 1'b0;
            endcase
        end
    end

    // Channel table effects
    // A conflict only counts for a single-PID channel
    wire prog_zero = prog_num_in == 16'h0000;
    wire no_match = chan_is_pid_in && !prog_zero && !prog_match_in;
    wire rate_bad = police_rate_in > `RATE_MAX;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pat_entry_out <= 1'b0;
            pmt_elem_out <= 1'b0;
            elem_stream_type_out <= 8'h00;
            low_prio_out <= 1'b0;
            cfg_err_out <= 1'b0;
        end else begin
            // Shared numbers share one PAT entry upstream
            pat_entry_out <= !prog_zero;
            pmt_elem_out <= chan_is_pid_in && !prog_zero &&
                prog_match_in;
            elem_stream_type_out <= stream_type_in;
            low_prio_out <= low_prio_in;
            cfg_err_out <= (chan_is_pid_in && pid_conflict_in) ||
                no_match ||
                resource_over_in || (|copy_bad) || vlan_bad ||
                ttl_bad || rate_bad;
        end
    end

    // Packet path: two-byte hold so the PID is known before emitting
    reg [7:0] idx_q;
    reg [7:0] h1_q;
    reg [7:0] h2_q;
    reg fill_q;
    reg keep_q;
    reg [19:0] credit_q;
    wire fifo_ready;
    wire fifo_vld;
    wire [7:0] fifo_data;
    wire take = in_valid_in && in_ready_out;
    wire [7:0] idx_now = in_sop_in ? 8'h00 :
        (idx_q == `PKT_LAST ? idx_q : idx_q + 8'h01);
    wire at_pid = take && idx_now == `IDX_PID_LO;
    wire [12:0] pid_now = {h1_q[4:0], in_data_in};
    wire pol_ok = police_rate_in == 8'h00 ||
        credit_q >= `PKT_BYTES * `BYTE_COST;
    wire keep_d = chan_is_pid_in && !rate_bad &&
        pid_now == chan_match_pid_in && pol_ok;
    wire keep_now = (idx_now == `IDX_PID_LO) ? keep_d : keep_q;
    wire wr_vld = take && fill_q && keep_now;
    wire [19:0] credit_add = credit_q + {12'h000, police_rate_in};
    wire [19:0] credit_inc = credit_add > `CREDIT_CAP ? `CREDIT_CAP :
        credit_add;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            idx_q <= `PKT_LAST;
            h1_q <= 8'h00;
            h2_q <= 8'h00;
            fill_q <= 1'b0;
            keep_q <= 1'b0;
            credit_q <= 20'h0_0000;
            in_ready_out <= 1'b0;
        end else begin
            // Full flag lags a cycle, so ready drops after each write;
            // half rate for kept bytes, but no write meets a full FIFO
            in_ready_out <= fifo_ready && !wr_vld;
            if (at_pid && keep_d && police_rate_in != 8'h00) begin
                credit_q <= credit_inc - `PKT_BYTES * `BYTE_COST;
            end else begin
                credit_q <= credit_inc;
            end
            if (take) begin
                idx_q <= idx_now;
                h2_q <= h1_q;
                if (idx_now == `IDX_PID_HI) begin
                    fill_q <= 1'b1;
                end
                if (at_pid) begin
                    keep_q <= keep_d;
                    // Only the PID bits change; flags and payload pass
                    h2_q <= keep_d ? {h1_q[7:5], chan_pid_in[12:8]} :
                        h1_q;
                    h1_q <= keep_d ? chan_pid_in[7:0] : in_data_in;
                end else begin
                    h1_q <= in_data_in;
                end
            end
        end
    end

    // Four bytes ride out short output stalls
    ts_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_valid_in(wr_vld),
        .wr_ready_out(fifo_ready),
        .wr_data_in(h2_q),
        .rd_valid_out(fifo_vld),
        .rd_ready_in(!out_valid_out || out_ready_in),
        .rd_data_out(fifo_data)
    );

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= 8'h00;
        end else if (!out_valid_out || out_ready_in) begin
            out_valid_out <= fifo_vld;
            out_data_out <= fifo_data;
        end
    end
endmodule // ts_channel_mux_config

// ### inc/ts_mux_consts.vh
// Purpose: constants for the transport stream routing and config block
// Assumes: 250 MHz core clock, 188-byte packets
// Notes: included by the channel config design file only
// Contract
// - Eight slots, each tied to same port
// - Mux slot drives its port as output
// - Demux slot takes its port as input
// - Off slot disables slot and port
// - Copy on even slot after mux slot
// - Up to 240 map entries, default -1
// - Default PIDs are offsets from base 48
// - VLAN 0 untagged, 1..4094 tagged
// - TTL placed into packets, 1..255 only
// - Protection fixed primary, secondary or automatic
// - Revert needs secondary fail, primary 30 s stable
// - Single-PID channel remaps PID and inserts
// - PID claimed elsewhere raises config error
// - Program 0 adds no PAT or PMT entry
// - Nonzero program needs match, adds PMT element
// - Same program numbers merge under one PAT
// - Police rate, 0 unlimited, 1..214 limit
// - Channel priority normal or low
// - Resource or constraint violation is config error
`ifndef TS_MUX_CONSTS_VH
`define TS_MUX_CONSTS_VH
`define SLOTS 8
`define TYPE_OFF 2'h0
`define TYPE_MUX 2'h1
`define TYPE_DMX 2'h2
`define TYPE_COPY 2'h3
`define MAP_ENTRIES 240
`define PID_NONE 16'hffff
`define PID_BASE 13'h0030
`define ELEM_DATA2 4'hc
`define ELEM_ECM 4'he
`define VLAN_MAX 12'h0ffe
`define TTL_MIN 8'h01
`define RATE_MAX 8'hd6
`define PKT_LAST 8'hbb
`define IDX_PID_HI 8'h01
`define IDX_PID_LO 8'h02
`define PKT_BYTES 20'h0_00bc
`define BYTE_COST 20'h0_07d0
`define CREDIT_CAP 20'hb_7980
`define PROT_PRI 2'h0
`define PROT_SEC 2'h1
`define PROT_AUTO 2'h2
`define STABLE_S 64'h0000_0000_0000_001e
`define CLK_HZ 64'h0000_0000_0ee6_b280
`endif

// ### test/ts_channel_mux_config_test.sv
// Purpose: self-checking bench for the stream routing and config block
// Assumes: short stable count of 20 cycles for protection revert
// Notes: stream bytes are noted by the driver, checked by a monitor
`timescale 1ns/1ps
module ts_channel_mux_config_test;
    reg clk_in, arst_n_in, map_wr_in, pri_fail_in, sec_fail_in, hold;
    reg chan_is_pid_in, prog_match_in, pid_conflict_in, resource_over_in;
    reg low_prio_in, in_valid_in, in_sop_in;
    reg [15:0] slot_type_in, prog_num_in;
    reg [7:0] slot_tx_in, map_wr_idx_in, map_rd_idx_in, ttl_in, in_data_in;
    reg [7:0] stream_type_in, police_rate_in;
    reg [12:0] map_wr_pid_in, chan_match_pid_in, chan_pid_in;
    reg [3:0] elem_sel_in;
    reg [11:0] vlan_id_in;
    reg [1:0] prot_mode_in, ty;
    wire [7:0] port_tx_out, port_drive_n_out, port_rx_en_out, slot_en_out;
    wire [15:0] map_rd_pid_out, def_pid_out;
    wire [11:0] vlan_tag_out;
    wire [7:0] ttl_out, elem_stream_type_out, out_data_out;
    wire vlan_tagged_out, sec_sel_out, pat_entry_out, pmt_elem_out;
    wire low_prio_out, cfg_err_out, in_ready_out, out_valid_out, out_ready_in;
    integer seed, n_mismatch, n_compared, i, k, t, w;
    reg [31:0] r;
    reg [7:0] exp_q [$];
    reg cp;
    ts_channel_mux_config #(.STABLE_CYCLES(33'h0_0000_0014), .FIFO_DEPTH(4))
        ts_channel_mux_config_i (.*);
    ts_stream_sink ts_stream_sink_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .hold_in(hold), .ready_out(out_ready_in));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input string nm, input [15:0] ex, input [15:0] got);
        n_compared = n_compared + 1;
        if (got !== ex) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task settle(input integer n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task chan(input [15:0] pn, input m, c, ro, input [7:0] rt, input [2:0] ex);
        @(posedge clk_in);
        prog_num_in <= pn;
        prog_match_in <= m;
        pid_conflict_in <= c;
        resource_over_in <= ro;
        police_rate_in <= rt;
        low_prio_in <= pn[0];
        settle(2);
        chk("cfg_err", ex[2], cfg_err_out);
        chk("pat", ex[1], pat_entry_out);
        chk("pmt", ex[0], pmt_elem_out);
        chk("prio", pn[0], low_prio_out);
    endtask
    task send_pkt(input [12:0] pid, input keep);
        reg [7:0] b;
        reg [7:0] e;
        for (k = 0; k < 188; k = k + 1) begin
            r = $random(seed);
            b = (k == 0) ? 8'h47 : (k == 2) ? pid[7:0] : r[7:0];
            if (k == 1) b[4:0] = pid[12:8];
            e = (k == 2) ? chan_pid_in[7:0] : b;
            if (k == 1) e[4:0] = chan_pid_in[12:8];
            if (keep) exp_q.push_back(e);
            @(posedge clk_in);
            in_valid_in <= 1'b1;
            in_sop_in <= (k == 0);
            in_data_in <= b;
            w = 0;
            @(negedge clk_in);
            while (in_ready_out !== 1'b1 && w < 500) begin
                @(negedge clk_in);
                w = w + 1;
            end
            if (w >= 500) begin
                n_mismatch = n_mismatch + 1;
                report_and_stop;
            end
        end
        @(posedge clk_in);
        in_valid_in <= 1'b0;
    endtask
    always @(posedge clk_in) begin
        if (arst_n_in && out_valid_out === 1'b1 && out_ready_in === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("extra byte", 16'h0000, 16'h0001);
            end else begin
                chk("out byte", exp_q.pop_front(), out_data_out);
            end
        end
    end
    initial begin
        repeat (100000) @(posedge clk_in);
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        seed = 67;
        n_mismatch = 0;
        n_compared = 0;
        {arst_n_in, map_wr_in, pri_fail_in, sec_fail_in, chan_is_pid_in} = 0;
        {prog_match_in, pid_conflict_in, resource_over_in, low_prio_in} = 0;
        {in_valid_in, in_sop_in, slot_type_in, prog_num_in, slot_tx_in} = 0;
        {map_wr_idx_in, map_rd_idx_in, in_data_in, stream_type_in} = 0;
        {police_rate_in, map_wr_pid_in, chan_match_pid_in, chan_pid_in} = 0;
        {elem_sel_in, vlan_id_in, prot_mode_in} = 0;
        ttl_in = 8'h40;
        hold = 1'b1;
        settle(8);
        chk("rst drive_n", 16'h00ff, port_drive_n_out);
        chk("rst map", 16'hffff, map_rd_pid_out);
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            @(posedge clk_in);
            slot_type_in <= (i == 0) ? 16'hdddd : (i == 1) ? 16'h7f03 : r[15:0];
            slot_tx_in <= r[23:16];
            settle(2);
            for (t = 0; t < 8; t = t + 1) begin
                ty = slot_type_in[2*t +: 2];
                cp = ty == 2'h3 && t % 2 == 1 &&
                    slot_type_in[2*t-2 +: 2] == 2'h1;
                chk("drive_n", ty != 2'h1 && !cp, port_drive_n_out[t]);
                chk("rx_en", ty == 2'h2, port_rx_en_out[t]);
                chk("tx", ty == 2'h1 ? slot_tx_in[t] : cp ? slot_tx_in[t-1] : 1'b0,
                    port_tx_out[t]);
                chk("slot_en", ty != 2'h0 && (ty != 2'h3 || cp),
                    slot_en_out[t]);
            end
        end
        $display("function map done");
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk_in);
            elem_sel_in <= i;
            slot_type_in <= 16'hdddd;
            settle(2);
            chk("def pid", (i < 13 || i == 14) ? 48 + i : 16'hffff,
                def_pid_out);
        end
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge clk_in);
            map_wr_in <= 1'b1;
            map_wr_idx_in <= 8'hef + i;
            map_wr_pid_in <= 13'h1abc + i;
            @(posedge clk_in);
            map_wr_in <= 1'b0;
            map_rd_idx_in <= 8'hef + i;
            settle(2);
            chk("map", i ? 16'hffff : 16'h1abc, map_rd_pid_out);
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_in);
            vlan_id_in <= (i == 0) ? 12'hfff : (i == 1) ? 12'h000 :
                (i == 2) ? 12'h001 : 12'hffe;
            ttl_in <= (i == 0) ? 8'h00 : (i == 1) ? 8'h01 :
                (i == 2) ? 8'hff : 8'h4d;
            settle(2);
            chk("tagged", i > 1, vlan_tagged_out);
            chk("vlan", i ? vlan_id_in : 16'h0000, vlan_tag_out);
            chk("ttl", i ? ttl_in : 16'h0001, ttl_out);
            chk("ip err", i == 0, cfg_err_out);
        end
        $display("maps and ip done");
        chan_is_pid_in <= 1'b1;
        stream_type_in <= 8'h06;
        chan(16'h0000, 0, 0, 0, 8'h00, 3'h0);
        chan(16'h0005, 0, 0, 0, 8'h00, 3'h6);
        chan(16'h0005, 1, 0, 0, 8'hd6, 3'h3);
        chk("stream type", 16'h0006, elem_stream_type_out);
        chan(16'h0002, 1, 1, 0, 8'h00, 3'h7);
        chan(16'h0002, 1, 0, 1, 8'h00, 3'h7);
        chan(16'h0002, 1, 0, 0, 8'hd7, 3'h7);
        chan(16'h0000, 0, 0, 0, 8'h00, 3'h0);
        $display("channel config done");
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge clk_in);
            prot_mode_in <= (i < 2) ? 2'h1 - i : 2'h2;
            pri_fail_in <= (i == 2);
            sec_fail_in <= (i >= 4 && i < 8);
            settle(i == 3 ? 5 : i == 5 ? 30 : 8);
            chk("sec_sel", i != 1 && i < 5, sec_sel_out);
        end
        $display("protection done");
        @(posedge clk_in);
        chan_match_pid_in <= 13'h0100;
        chan_pid_in <= 13'h003b;
        fork
            send_pkt(13'h0100, 1'b1);
            begin
                settle(40);
                chk("in_ready full", 16'h0000, in_ready_out);
                hold <= 1'b0;
            end
        join
        send_pkt(13'h0101, 1'b0);
        send_pkt(13'h0100, 1'b1);
        police_rate_in <= 8'hd7;
        send_pkt(13'h0100, 1'b0);
        w = 0;
        while (exp_q.size() != 0 && w < 1000) begin
            @(posedge clk_in);
            w = w + 1;
        end
        chk("bytes left", 16'h0000, exp_q.size());
        $display("stream done");
        report_and_stop;
    end
endmodule // ts_channel_mux_config_test

// ### test/ts_mux_cfg_asserts.sv
// Purpose: port checker for the stream routing and config block
// Assumes: config outputs follow their inputs one cycle later
// Notes: up_q masks the first edges after reset release
`timescale 1ns/1ps
module ts_mux_cfg_asserts (
    input wire clk_in,
    input wire arst_n_in,
    input wire [15:0] slot_type_in,
    input wire [7:0] port_tx_out,
    input wire [7:0] port_drive_n_out,
    input wire [7:0] port_rx_en_out,
    input wire [7:0] slot_en_out,
    input wire [3:0] elem_sel_in,
    input wire [15:0] def_pid_out,
    input wire [11:0] vlan_id_in,
    input wire [7:0] ttl_in,
    input wire vlan_tagged_out,
    input wire [11:0] vlan_tag_out,
    input wire [7:0] ttl_out,
    input wire [1:0] prot_mode_in,
    input wire sec_sel_out,
    input wire [15:0] prog_num_in,
    input wire chan_is_pid_in,
    input wire pid_conflict_in,
    input wire low_prio_in,
    input wire pat_entry_out,
    input wire pmt_elem_out,
    input wire low_prio_out,
    input wire cfg_err_out,
    input wire out_valid_out,
    input wire out_ready_in
);
    reg [1:0] up_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            up_q <= 2'h0;
        end else begin
            up_q <= {up_q[0], 1'b1};
        end
    end
    property p_mux_drive;
        up_q[1] |-> port_drive_n_out[0] == ($past(slot_type_in[1:0]) != 2'h1);
    endproperty
    a_mux_drive: assert property (p_mux_drive) else $error("mux drive");
    property p_dmx_rx;
        up_q[1] && $past(slot_type_in[3:2]) == 2'h2
            |-> port_rx_en_out[1] && port_drive_n_out[1];
    endproperty
    a_dmx_rx: assert property (p_dmx_rx) else $error("demux input");
    property p_off;
        up_q[1] && $past(slot_type_in[5:4]) == 2'h0
            |-> !slot_en_out[2] && port_drive_n_out[2] && !port_rx_en_out[2];
    endproperty
    a_off: assert property (p_off) else $error("off slot");
    property p_copy;
        up_q[1] && $past(slot_type_in[3:0]) == 4'hd
            |-> !port_drive_n_out[1] && port_tx_out[1] == port_tx_out[0];
    endproperty
    a_copy: assert property (p_copy) else $error("copy port");
    property p_def_ecm;
        up_q[1] && $past(elem_sel_in) == 4'he |-> def_pid_out == 16'h003e;
    endproperty
    a_def_ecm: assert property (p_def_ecm) else $error("ecm pid");
    property p_vlan;
        up_q[1] && $past(vlan_id_in) != 12'hfff
            |-> vlan_tagged_out == ($past(vlan_id_in) != 12'h000)
            && vlan_tag_out == $past(vlan_id_in);
    endproperty
    a_vlan: assert property (p_vlan) else $error("vlan tag");
    property p_ttl;
        up_q[1] && $past(ttl_in) != 8'h00 |-> ttl_out == $past(ttl_in);
    endproperty
    a_ttl: assert property (p_ttl) else $error("ttl value");
    property p_prog0;
        up_q[1] && $past(prog_num_in) == 16'h0000
            |-> !pat_entry_out && !pmt_elem_out;
    endproperty
    a_prog0: assert property (p_prog0) else $error("program zero");
    property p_conflict;
        up_q[1] && $past(pid_conflict_in && chan_is_pid_in) |-> cfg_err_out;
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict");
    property p_prio;
        up_q[1] |-> low_prio_out == $past(low_prio_in);
    endproperty
    a_prio: assert property (p_prio) else $error("priority");
    property p_fixed_sec;
        (prot_mode_in == 2'h1) [*7] |-> sec_sel_out;
    endproperty
    a_fixed_sec: assert property (p_fixed_sec) else $error("fixed sec");
    c_stream: cover property (out_valid_out && out_ready_in);
    c_sec: cover property (prot_mode_in == 2'h2 && sec_sel_out);
    c_err: cover property (cfg_err_out);
endmodule // ts_mux_cfg_asserts

bind ts_channel_mux_config ts_mux_cfg_asserts ts_mux_cfg_asserts_i (.*);

// ### test/ts_stream_sink.sv
// Purpose: downstream receiver that stalls the output stream
// Assumes: hold_in forces a full stall, else ready is random
// Notes: own seed so stalls do not shift the payload sequence
`timescale 1ns/1ps
module ts_stream_sink (
    input wire clk_in,
    input wire arst_n_in,
    input wire hold_in,
    output reg ready_out
);
    integer seed;
    reg [31:0] r;
    initial seed = 67;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ready_out <= 1'b0;
        end else begin
            r = $random(seed);
            ready_out <= !hold_in && r[1:0] != 2'h0;
        end
    end
endmodule // ts_stream_sink
